// [src/uspa_top.sv]
// unsigned saturating simd and halfword pack datapath slice
// Contract
// - exchange add-sub: clamped sum to top half
// - exchange add-sub: clamped difference to bottom half
// - sub-add: top minus bottom, clamp, top
// - sub-add: bottom plus top, clamp, bottom
// - dual halfword add, each clamped to 65535
// - quad byte add, each clamped to 255
// - dual halfword subtract, underflow gives zero
// - quad byte subtract, underflow gives zero
// - saturating ops leave condition flags alone
// - omitted destination writes first operand register
// - bottom-top pack keeps first operand bottom half
// - bottom-top pack top from shifted second
// - top-bottom pack keeps first operand top half
// - top-bottom pack bottom from shifted second
// - left shift 1 to 31, zero none
// - arithmetic right shift, zero means 32
// - pack operations leave status flags alone
`include "uspa_defines.svh"
module uspa_top
  import uspa_pkg::*;
(
  // clock and reset
  input wire logic I_MCLK,
  input wire logic I_RSTN,
  // issue from the decoder
  input wire logic I_VALID,
  input wire logic I_COND_PASS,
  input uspa_op_t I_OP,
  input wire logic [`USPA_W-1:0] I_FIRST_OPERAND,
  input wire logic [`USPA_W-1:0] I_SECOND_OPERAND,
  input wire logic [`USPA_REGW-1:0] I_FIRST_OPERAND_REG,
  input wire logic I_DEST_GIVEN,
  input wire logic [`USPA_REGW-1:0] I_DEST_REG,
  input wire logic [`USPA_SHW-1:0] I_SHIFT,
  input wire logic [3:0] I_FLAGS,
  // write back to the register file
  output logic O_WR_EN,
  output logic [`USPA_REGW-1:0] O_WR_REG,
  output logic [`USPA_W-1:0] O_WR_DATA,
  output logic [3:0] O_FLAGS
);
  uspa_lane_if lif();
  uspa_satlane u_lane
  (
    .lif(lif)
  );

  logic take;
  logic sh_zero;

  logic wr_en_q;
  logic wr_en_d;
  logic [`USPA_REGW-1:0] wr_reg_q;
  logic [`USPA_REGW-1:0] wr_reg_d;
  logic [`USPA_W-1:0] wr_data_q;
  logic [`USPA_W-1:0] wr_data_d;
  logic [`USPA_FLW-1:0] flags_q;
  logic [`USPA_FLW-1:0] flags_d;

  logic [`USPA_W-1:0] shl;
  logic [`USPA_W-1:0] sar;
  logic [`USPA_W-1:0] pk_bt;
  logic [`USPA_W-1:0] pk_tb;
  logic [`USPA_W-1:0] result;

  logic [`USPA_HW-1:0] a_hi;
  logic [`USPA_HW-1:0] a_lo;
  logic [`USPA_HW-1:0] b_hi;
  logic [`USPA_HW-1:0] b_lo;

  assign take = I_VALID && I_COND_PASS;
  assign sh_zero = I_SHIFT == `USPA_SH_ZERO;

  // operand halves
  assign a_hi = I_FIRST_OPERAND[`USPA_W-1:`USPA_HW];
  assign a_lo = I_FIRST_OPERAND[`USPA_HW-1:0];
  assign b_hi = I_SECOND_OPERAND[`USPA_W-1:`USPA_HW];
  assign b_lo = I_SECOND_OPERAND[`USPA_HW-1:0];

  // operand steering into the lane unit
  always_comb
  begin
    lif.a = I_FIRST_OPERAND;
    lif.b = I_SECOND_OPERAND;
    lif.byte_mode = `USPA_LANES_NONE;
    lif.sub_lane = `USPA_LANES_NONE;
    unique case (I_OP)
      USPA_ASX:
      begin
        // top = a_hi + b_lo, bottom = a_lo - b_hi
        lif.b = {b_lo, b_hi};
        lif.sub_lane = `USPA_LANES_LO;
      end
      USPA_SAX:
      begin
        // top = a_hi - b_lo, bottom = a_lo + b_hi
        lif.b = {b_lo, b_hi};
        lif.sub_lane = `USPA_LANES_HI;
      end
      USPA_ADD16:
      begin
        lif.sub_lane = `USPA_LANES_NONE;
      end
      USPA_ADD8:
      begin
        lif.byte_mode = `USPA_LANES_ALL;
      end
      USPA_SUB16:
      begin
        lif.sub_lane = `USPA_LANES_ALL;
      end
      USPA_SUB8:
      begin
        lif.byte_mode = `USPA_LANES_ALL;
        lif.sub_lane = `USPA_LANES_ALL;
      end
      USPA_PKBT:
      begin
        lif.sub_lane = `USPA_LANES_NONE;
      end
      USPA_PKTB:
      begin
        lif.sub_lane = `USPA_LANES_NONE;
      end
    endcase
  end

  // left shifter, zero field passes the operand through
  always_comb
  begin
    if (sh_zero)
    begin
      shl = I_SECOND_OPERAND;
    end
    else
    begin
      shl = I_SECOND_OPERAND << I_SHIFT;
    end
  end

  // right shifter, zero field is a full-width shift
  always_comb
  begin
    if (sh_zero)
    begin
      sar = {`USPA_W{I_SECOND_OPERAND[`USPA_W-1]}};
    end
    else
    begin
      sar = $signed(I_SECOND_OPERAND) >>> I_SHIFT;
    end
  end

  // pack word assembly
  always_comb
  begin
    pk_bt = {shl[`USPA_W-1:`USPA_HW], a_lo};
    pk_tb = {a_hi, sar[`USPA_HW-1:0]};
  end

  // result select
  always_comb
  begin
    result = lif.res;
    unique case (I_OP)
      USPA_ASX:
      begin
        result = lif.res;
      end
      USPA_SAX:
      begin
        result = lif.res;
      end
      USPA_ADD16:
      begin
        result = lif.res;
      end
      USPA_ADD8:
      begin
        result = lif.res;
      end
      USPA_SUB16:
      begin
        result = lif.res;
      end
      USPA_SUB8:
      begin
        result = lif.res;
      end
      USPA_PKBT:
      begin
        result = pk_bt;
      end
      USPA_PKTB:
      begin
        result = pk_tb;
      end
    endcase
  end

  // write enable, one cycle per taken op
  always_comb
  begin
    wr_en_d = 1'b0;
    if (take)
    begin
      wr_en_d = 1'b1;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      wr_en_q <= 1'b0;
    end
    else
    begin
      wr_en_q <= wr_en_d;
    end
  end

  // destination, held between taken ops
  always_comb
  begin
    wr_reg_d = wr_reg_q;
    if (take)
    begin
      if (I_DEST_GIVEN)
      begin
        wr_reg_d = I_DEST_REG;
      end
      else
      begin
        wr_reg_d = I_FIRST_OPERAND_REG;
      end
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      wr_reg_q <= `USPA_ZERO4;
    end
    else
    begin
      wr_reg_q <= wr_reg_d;
    end
  end

  // result word, held between taken ops
  always_comb
  begin
    wr_data_d = wr_data_q;
    if (take)
    begin
      wr_data_d = result;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      wr_data_q <= `USPA_ZERO32;
    end
    else
    begin
      wr_data_q <= wr_data_d;
    end
  end

  // flags pass through unchanged
  always_comb
  begin
    flags_d = flags_q;
    if (take)
    begin
      flags_d = I_FLAGS;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      flags_q <= `USPA_ZERO4;
    end
    else
    begin
      flags_q <= flags_d;
    end
  end

  assign O_WR_EN = wr_en_q;
  assign O_WR_REG = wr_reg_q;
  assign O_WR_DATA = wr_data_q;
  assign O_FLAGS = flags_q;
endmodule

// [src/uspa_defines.svh]
// constants for the unsigned saturate and pack datapath
`ifndef USPA_DEFINES_SVH
`define USPA_DEFINES_SVH
`define USPA_W 32
`define USPA_HW 16
`define USPA_REGW 4
`define USPA_SHW 5
`define USPA_OPW 3
`define USPA_FLW 4
`define USPA_LANES_NONE 4'h0
`define USPA_LANES_LO 4'h3
`define USPA_LANES_HI 4'hC
`define USPA_LANES_ALL 4'hF
`define USPA_OP_ASX 3'h0
`define USPA_OP_SAX 3'h1
`define USPA_OP_ADD16 3'h2
`define USPA_OP_ADD8 3'h3
`define USPA_OP_SUB16 3'h4
`define USPA_OP_SUB8 3'h5
`define USPA_OP_PKBT 3'h6
`define USPA_OP_PKTB 3'h7
`define USPA_ZERO32 32'h0000_0000
`define USPA_ZERO4 4'h0
`define USPA_SH_ZERO 5'h00
`define USPA_SH_FULL 6'h20
`endif

// [src/uspa_pkg.sv]
// types for the unsigned saturate and pack datapath
`include "uspa_defines.svh"
package uspa_pkg;
  typedef enum logic [`USPA_OPW-1:0] {
    USPA_ASX = `USPA_OP_ASX,
    USPA_SAX = `USPA_OP_SAX,
    USPA_ADD16 = `USPA_OP_ADD16,
    USPA_ADD8 = `USPA_OP_ADD8,
    USPA_SUB16 = `USPA_OP_SUB16,
    USPA_SUB8 = `USPA_OP_SUB8,
    USPA_PKBT = `USPA_OP_PKBT,
    USPA_PKTB = `USPA_OP_PKTB
  } uspa_op_t;
endpackage

// [src/uspa_lane_if.sv]
// operand and result lanes between the top and the saturating lane unit
`include "uspa_defines.svh"
interface uspa_lane_if;
  logic [`USPA_W-1:0] a;
  logic [`USPA_W-1:0] b;
  logic [3:0] byte_mode;
  logic [3:0] sub_lane;
  logic [`USPA_W-1:0] res;
  modport top (output a, output b, output byte_mode, output sub_lane, input res);
  modport lane (input a, input b, input byte_mode, input sub_lane, output res);
endinterface

// [src/uspa_satlane.sv]
// four byte slices with carry chaining, unsigned clamp per byte or halfword
`include "uspa_defines.svh"
module uspa_satlane
(
  uspa_lane_if.lane lif
);
  logic [8:0] sum [4];
  logic [3:0] cin;
  logic [3:0] ovf;
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_byte
      // a halfword lane chains the low byte carry into the high byte
      if (g % 2 == 0)
      begin : g_lo
        assign cin[g] = lif.sub_lane[g];
      end
      else
      begin : g_hi
        assign cin[g] = lif.byte_mode[g] ? lif.sub_lane[g] : sum[g-1][8];
      end
      assign sum[g] = {1'b0, lif.a[8*g+7:8*g]}
        + {1'b0, (lif.sub_lane[g] ? ~lif.b[8*g+7:8*g] : lif.b[8*g+7:8*g])}
        + {8'h00, cin[g]};
      // add overflows on carry out, subtract underflows on no carry
      assign ovf[g] = lif.sub_lane[g] ? ~sum[g][8] : sum[g][8];
    end
    for (g = 0; g < 4; g++)
    begin : g_clamp
      logic clamp;
      if (g % 2 == 0)
      begin : g_c0
        assign clamp = lif.byte_mode[g] ? ovf[g] : ovf[g+1];
      end
      else
      begin : g_c1
        assign clamp = ovf[g];
      end
      assign lif.res[8*g+7:8*g] = clamp ? (lif.sub_lane[g] ? 8'h00 : 8'hFF) : sum[g][7:0];
    end
  endgenerate
endmodule

// [verification/uspa_checker.sv]
// port assertions for the saturate and pack datapath
module uspa_checker
  import uspa_pkg::*;
(
  // issue side
  input logic I_MCLK,
  input logic I_RSTN,
  input logic I_VALID,
  input logic I_COND_PASS,
  input uspa_op_t I_OP,
  input logic [31:0] I_FIRST_OPERAND,
  input logic [3:0] I_FIRST_OPERAND_REG,
  input logic I_DEST_GIVEN,
  input logic [3:0] I_FLAGS,
  // write-back side
  input logic O_WR_EN,
  input logic [3:0] O_WR_REG,
  input logic [31:0] O_WR_DATA,
  input logic [3:0] O_FLAGS
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RSTN);
  sequence s_t;
    I_VALID && I_COND_PASS;
  endsequence
  sequence s_op(uspa_op_t o);
    s_t ##0 I_OP == o;
  endsequence
  property p_wr; s_t |=> O_WR_EN; endproperty
  property p_no; !(I_VALID && I_COND_PASS) |=> !O_WR_EN && $stable(O_WR_DATA); endproperty
  property p_fl; s_t |=> O_FLAGS == $past(I_FLAGS); endproperty
  property p_rd; s_t ##0 !I_DEST_GIVEN |=> O_WR_REG == $past(I_FIRST_OPERAND_REG); endproperty
  property p_bt; s_op(USPA_PKBT) |=> O_WR_DATA[15:0] == $past(I_FIRST_OPERAND[15:0]); endproperty
  property p_tb; s_op(USPA_PKTB) |=> O_WR_DATA[31:16] == $past(I_FIRST_OPERAND[31:16]); endproperty
  property p_ad; s_op(USPA_ADD16) |=> O_WR_DATA[15:0] >= $past(I_FIRST_OPERAND[15:0]); endproperty
  property p_sb; s_op(USPA_SUB8) |=> O_WR_DATA[7:0] <= $past(I_FIRST_OPERAND[7:0]); endproperty
  a_wr: assert property (p_wr) else $error("write missing");
  a_no: assert property (p_no) else $error("refused op wrote");
  a_fl: assert property (p_fl) else $error("flags changed");
  a_rd: assert property (p_rd) else $error("wrong default dest");
  a_bt: assert property (p_bt) else $error("pack bottom lost");
  a_tb: assert property (p_tb) else $error("pack top lost");
  a_ad: assert property (p_ad) else $error("add wrapped");
  a_sb: assert property (p_sb) else $error("sub wrapped");
endmodule
bind uspa_top uspa_checker u_chk (.I_MCLK, .I_RSTN, .I_VALID, .I_COND_PASS, .I_OP,
  .I_FIRST_OPERAND, .I_FIRST_OPERAND_REG, .I_DEST_GIVEN, .I_FLAGS, .O_WR_EN, .O_WR_REG,
  .O_WR_DATA, .O_FLAGS);

// [verification/uspa_regfile_model.sv]
// register file taking the write-back
module uspa_regfile_model
(
  input logic i_clk,
  input logic i_wen,
  input logic [3:0] i_reg,
  input logic [31:0] i_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rf_q [16];
  always @(posedge i_clk)
    if (i_wen)
      rf_q[i_reg] <= i_data;
endmodule

// [verification/uspa_tb_top.sv]
// self-checking bench for the saturate and pack datapath
module unsigned_simd_saturate_pack_alu_tb_top
  import uspa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, vld = 0, cnd = 0, dg = 0, e_en = 0, w_en;
  uspa_op_t op = USPA_ASX;
  logic [31:0] a = 0, b = 0, e_d = 0, w_d;
  logic [3:0] fr = 0, dr = 0, fl = 0, e_r = 0, e_f = 0, w_r, w_f;
  logic [4:0] sh = 0;
  int num_errors = 0, n_checks = 0;
  logic [36:0] pend [$];
  logic [36:0] rec;
  uspa_top u_dut (.I_MCLK(clk), .I_RSTN(rstn), .I_VALID(vld), .I_COND_PASS(cnd), .I_OP(op),
    .I_FIRST_OPERAND(a), .I_SECOND_OPERAND(b), .I_FIRST_OPERAND_REG(fr), .I_DEST_GIVEN(dg),
    .I_DEST_REG(dr), .I_SHIFT(sh), .I_FLAGS(fl), .O_WR_EN(w_en), .O_WR_REG(w_r),
    .O_WR_DATA(w_d), .O_FLAGS(w_f));
  uspa_regfile_model u_rf (.i_clk(clk), .i_wen(w_en), .i_reg(w_r), .i_data(w_d));
  initial forever #2 clk = ~clk;
  function automatic int st(int v, int w);
    return v < 0 ? 0 : (v >= 1 << w ? (1 << w) - 1 : v);
  endfunction
  function automatic int ln(logic [31:0] x, int i, int w);
    return int'((x >> i * w) & ((32'h1 << w) - 1));
  endfunction
  function automatic logic [31:0] model(uspa_op_t o, logic [31:0] x, logic [31:0] y, int s);
    logic [31:0] r;
    logic signed [31:0] t;
    int w;
    r = 0;
    w = (o == USPA_ADD8 || o == USPA_SUB8) ? 8 : 16;
    t = $signed(y) >>> (s == 0 ? 31 : s);
    case (o)
      USPA_ASX: r = st(ln(x,1,16)+ln(y,0,16),16) << 16 | st(ln(x,0,16)-ln(y,1,16),16);
      USPA_SAX: r = st(ln(x,1,16)-ln(y,0,16),16) << 16 | st(ln(x,0,16)+ln(y,1,16),16);
      USPA_PKBT: r = (y << s) & 32'hFFFF0000 | x & 32'h0000FFFF;
      USPA_PKTB: r = x & 32'hFFFF0000 | t & 32'h0000FFFF;
      default:
        for (int i = 0; i < 32 / w; i++)
          r |= st(ln(x,i,w) + (o > USPA_ADD8 ? -ln(y,i,w) : ln(y,i,w)), w) << i * w;
    endcase
    return r;
  endfunction
  task automatic cmp_en(logic got, logic exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t write enable got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic cmp_reg(logic [3:0] got, logic [3:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t dest reg got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_data(logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t result got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_flags(logic [3:0] got, logic [3:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t flags got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_rf(logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t regfile word got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    void'($urandom(3));
    repeat (20) @(negedge clk);
    rstn = 1;
    for (int i = 0; i < 3000; i++)
    begin
      @(negedge clk);
      cmp_en(w_en, e_en);
      cmp_reg(w_r, e_r);
      cmp_data(w_d, e_d);
      cmp_flags(w_f, e_f);
      if (pend.size() == 2)
      begin
        rec = pend.pop_front();
        if (rec[36])
          cmp_rf(u_rf.rf_q[rec[35:32]], rec[31:0]);
      end
      vld = $urandom % 8 != 0;
      cnd = $urandom % 4 != 0;
      dg = $urandom % 2;
      op = uspa_op_t'(i % 8);
      a = $urandom % 4 ? $urandom : 32'hFFFFFFFF;
      b = $urandom % 4 ? $urandom : (i % 3 ? 32'hFFFFFFFF : 32'h0);
      sh = $urandom % 3 ? $urandom : 5'h00;
      fr = $urandom % 13;
      dr = $urandom % 13;
      fl = $urandom;
      e_en = vld && cnd;
      if (e_en)
      begin
        e_r = dg ? dr : fr;
        e_d = model(op, a, b, sh);
        e_f = fl;
      end
      pend.push_back({e_en, e_r, e_d});
    end
    give_verdict();
  end
endmodule
